//--- hw/pin_mux_pkg.sv
package pin_mux_pkg;
   localparam int PA_W = 12;
   localparam int PD_W = 5;
   localparam int PWM_MODS = 2;
   localparam int PWM_SUBS = 4;
   localparam int PWM_PINS_PER_SUB = 3;
   localparam int PWM_W = PWM_MODS * PWM_SUBS * PWM_PINS_PER_SUB;
   localparam int FAULT_W = 4;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;
   localparam int RST_RELEASE_CYCLES = 32;

   localparam logic [ADDR_W-1:0] ADDR_PA_DATA = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_PA_DIR = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_PA_PER = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_PA_PIN = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_PD_DATA = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_PD_DIR = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_PD_PER = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_PD_PIN = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_PSEL = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_ADC_CTRL = 4'h9;
   localparam logic [ADDR_W-1:0] ADDR_PWM_MODE = 4'hA;
   localparam logic [ADDR_W-1:0] ADDR_PWM_FMASK = 4'hB;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hC;

   localparam logic [PA_W-1:0] PA_PER_RST = 12'h000;
   localparam logic [PD_W-1:0] PD_PER_RST = 5'h1F;

   // port D bit positions
   localparam int PD_TDI = 0;
   localparam int PD_TDO = 1;
   localparam int PD_TCK = 2;
   localparam int PD_TMS = 3;
   localparam int PD_RST = 4;

   // port A pin that carries the comparator C output
   localparam int PA_CMPC_BIT = 0;
   localparam int PA_REFH_BIT = 2;
   localparam int PA_REFL_BIT = 3;
   // converter control fields
   localparam int ADC_REFH_SEL = 0;
   localparam int ADC_REFL_SEL = 1;
endpackage : pin_mux_pkg

//--- hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_s;
   sync_s st_ff;
   sync_s nxt_st;

   always_comb begin
      nxt_st.meta = d;
      nxt_st.stable = st_ff.meta;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= {INIT, INIT};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.stable;
endmodule : pin_sync

//--- hw/reset_release.sv
`timescale 1ns/1ps
module reset_release #(
   parameter int CYCLES = pin_mux_pkg::RST_RELEASE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hold,
   output logic sys_reset_n
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(CYCLES - 1);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic rel;
   } rel_s;
   rel_s st_ff;
   rel_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (hold) begin
         nxt_st.cnt = '0; // RULE10
         nxt_st.rel = 1'b0;
      end else if (!st_ff.rel) begin
         if (st_ff.cnt == CNT_MAX) begin
            nxt_st.rel = 1'b1; // RULE11
         end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sys_reset_n = st_ff.rel;

   chk_hold_resets: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE10
      hold |=> !sys_reset_n) else $error("reset hold did not keep system in reset");
   chk_release_count: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE11
      $rose(sys_reset_n) |-> ($past(st_ff.cnt) == CNT_MAX) && !$past(hold))
      else $error("system reset released at wrong count");
endmodule : reset_release

//--- hw/pin_function_select.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - after any reset every pin sits on its primary function with no alternative routed; here only resetn reloads it, not watchdog or software reset.
// RULE2 - an alternative function reaches a pin only once its enable bit and select field are set.
// RULE3 - each port bit has its own direction bit, written without touching the others.
// RULE4 - each of the 24 pulse-width pins is either a waveform output or a capture input.
// RULE5 - fault inputs are routed in and can switch off selected pulse-width outputs.
// RULE6 - the external watchdog output pin is low while the watchdog condition is asserted.
// RULE7 - after reset the test data pin is a test input sampled on a test clock rise, pulled up.
// RULE8 - test data out is driven only in the shift states and changes on a test clock fall.
// RULE9 - the test mode pin is sampled on a test clock rise and is pulled up.
// RULE10 - while the reset pin is low in its reset function the system is held in reset.
// RULE11 - after the reset pin goes high the system reset ends after a fixed cycle count.
// RULE12 - as a port bit the reset pin is input or open-drain output and no longer resets.
// RULE13 - during reset the test and reset pins are inputs with pullups on.
// RULE14 - each port A pin is a port bit after reset and an input while reset is active.
// RULE15 - port A bits 2 and 3 are analog channel or converter reference by converter control.
// RULE16 - port A bit 0 can drive the comparator C output onto the pin when selected.
// RULE17 - with its enable bit clear a pin follows port direction and data, whatever the select.
module pin_function_select #(
   parameter int RST_CYCLES = pin_mux_pkg::RST_RELEASE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [pin_mux_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pin_mux_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pin_mux_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [pin_mux_pkg::PA_W-1:0] pa_in,
   output logic [pin_mux_pkg::PA_W-1:0] pa_out,
   output logic [pin_mux_pkg::PA_W-1:0] pa_oe,
   output logic [pin_mux_pkg::PA_W-1:0] pa_analog_en,
   output logic adc_a_channel2_en,
   output logic adc_a_ref_high_en,
   output logic adc_a_channel3_en,
   output logic adc_a_ref_low_en,
   input wire logic comparator_c_out,
   input wire logic [pin_mux_pkg::PD_W-1:0] pd_in,
   output logic [pin_mux_pkg::PD_W-1:0] pd_out,
   output logic [pin_mux_pkg::PD_W-1:0] pd_oe,
   output logic [pin_mux_pkg::PD_W-1:0] pd_pullup_en,
   output logic tap_tdi,
   output logic tap_tms,
   output logic tap_tck_rise,
   input wire logic tap_tdo,
   input wire logic tap_shift,
   input wire logic watchdog_reset_source,
   input wire logic sw_reset_req,
   output logic sys_reset_n,
   input wire logic ewm_assert,
   output logic ext_watchdog_out_n,
   input wire logic [pin_mux_pkg::PWM_W-1:0] pwm_sub_pin_in,
   output logic [pin_mux_pkg::PWM_W-1:0] pwm_sub_pin_out,
   output logic [pin_mux_pkg::PWM_W-1:0] pwm_sub_pin_oe,
   input wire logic [pin_mux_pkg::PWM_W-1:0] pwm_wave,
   output logic [pin_mux_pkg::PWM_W-1:0] pwm_capture,
   input wire logic [pin_mux_pkg::FAULT_W-1:0] pwm_fault_in,
   output logic [pin_mux_pkg::FAULT_W-1:0] pwm_fault
);
   localparam int PA_W = pin_mux_pkg::PA_W;
   localparam int PD_W = pin_mux_pkg::PD_W;
   localparam int PWM_W = pin_mux_pkg::PWM_W;
   localparam int FAULT_W = pin_mux_pkg::FAULT_W;
   localparam int DATA_W = pin_mux_pkg::DATA_W;
   localparam int SYNC_W = PA_W + PD_W + PWM_W + FAULT_W;

   typedef struct packed {
      logic [PA_W-1:0] pa_data;
      logic [PA_W-1:0] pa_dir;
      logic [PA_W-1:0] pa_per;
      logic [PA_W-1:0] peripheral_select_reg;
      logic [PD_W-1:0] pd_data;
      logic [PD_W-1:0] pd_dir;
      logic [PD_W-1:0] pd_per;
      logic [1:0] adc_ctrl;
      logic [PWM_W-1:0] pwm_cap_mode;
      logic [PWM_W-1:0] pwm_fmask;
      logic [DATA_W-1:0] rdata;
      logic tck_prev;
      logic tdi_smp;
      logic tms_smp;
      logic tck_rise;
      logic tdo_q;
      logic wdog_n;
   } mux_s;
   mux_s st_ff;
   mux_s nxt_st;

   logic [SYNC_W-1:0] sync_q;
   logic [PA_W-1:0] pa_s;
   logic [PD_W-1:0] pd_s;
   logic [PWM_W-1:0] pwm_s;
   logic [FAULT_W-1:0] fault_s;
   logic fault_any;
   logic pin_rst_req;
   logic [PA_W-1:0] pa_alt;

   // pins are asynchronous to clk_sys; idle high so a pulled-up reset pin is not seen low
   pin_sync #(.W(SYNC_W), .INIT({SYNC_W{1'b1}})) u_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .d({pa_in, pd_in, pwm_sub_pin_in, pwm_fault_in}),
      .q(sync_q)
   );
   assign {pa_s, pd_s, pwm_s, fault_s} = sync_q;
   assign fault_any = |fault_s;

   // pin reset counts only while the pin keeps its reset function
   assign pin_rst_req = st_ff.pd_per[pin_mux_pkg::PD_RST] & ~pd_s[pin_mux_pkg::PD_RST]; // RULE12

   reset_release #(.CYCLES(RST_CYCLES)) u_rst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .hold(pin_rst_req | watchdog_reset_source | sw_reset_req), // RULE10
      .sys_reset_n(sys_reset_n)
   );

   always_comb begin
      nxt_st = st_ff;
      if (reg_wr) begin
         case (reg_addr)
            pin_mux_pkg::ADDR_PA_DATA: nxt_st.pa_data = reg_wdata[PA_W-1:0];
            pin_mux_pkg::ADDR_PA_DIR: nxt_st.pa_dir = reg_wdata[PA_W-1:0]; // RULE3
            pin_mux_pkg::ADDR_PA_PER: nxt_st.pa_per = reg_wdata[PA_W-1:0]; // RULE2
            pin_mux_pkg::ADDR_PD_DATA: nxt_st.pd_data = reg_wdata[PD_W-1:0];
            pin_mux_pkg::ADDR_PD_DIR: nxt_st.pd_dir = reg_wdata[PD_W-1:0]; // RULE3
            pin_mux_pkg::ADDR_PD_PER: nxt_st.pd_per = reg_wdata[PD_W-1:0];
            pin_mux_pkg::ADDR_PSEL: nxt_st.peripheral_select_reg = reg_wdata[PA_W-1:0]; // RULE2
            pin_mux_pkg::ADDR_ADC_CTRL: nxt_st.adc_ctrl = reg_wdata[1:0]; // RULE15
            pin_mux_pkg::ADDR_PWM_MODE: nxt_st.pwm_cap_mode = reg_wdata[PWM_W-1:0]; // RULE4
            pin_mux_pkg::ADDR_PWM_FMASK: nxt_st.pwm_fmask = reg_wdata[PWM_W-1:0]; // RULE5
            default: ;
         endcase
      end
      nxt_st.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            pin_mux_pkg::ADDR_PA_DATA: nxt_st.rdata = DATA_W'(st_ff.pa_data);
            pin_mux_pkg::ADDR_PA_DIR: nxt_st.rdata = DATA_W'(st_ff.pa_dir);
            pin_mux_pkg::ADDR_PA_PER: nxt_st.rdata = DATA_W'(st_ff.pa_per);
            pin_mux_pkg::ADDR_PA_PIN: nxt_st.rdata = DATA_W'(pa_s);
            pin_mux_pkg::ADDR_PD_DATA: nxt_st.rdata = DATA_W'(st_ff.pd_data);
            pin_mux_pkg::ADDR_PD_DIR: nxt_st.rdata = DATA_W'(st_ff.pd_dir);
            pin_mux_pkg::ADDR_PD_PER: nxt_st.rdata = DATA_W'(st_ff.pd_per);
            pin_mux_pkg::ADDR_PD_PIN: nxt_st.rdata = DATA_W'(pd_s);
            pin_mux_pkg::ADDR_PSEL: nxt_st.rdata = DATA_W'(st_ff.peripheral_select_reg);
            pin_mux_pkg::ADDR_ADC_CTRL: nxt_st.rdata = DATA_W'(st_ff.adc_ctrl);
            pin_mux_pkg::ADDR_PWM_MODE: nxt_st.rdata = DATA_W'(st_ff.pwm_cap_mode);
            pin_mux_pkg::ADDR_PWM_FMASK: nxt_st.rdata = DATA_W'(st_ff.pwm_fmask);
            pin_mux_pkg::ADDR_STATUS: nxt_st.rdata = DATA_W'({tap_shift, sys_reset_n, fault_s});
            default: nxt_st.rdata = '0;
         endcase
      end
      // test pins: rise samples the inputs, fall moves the output
      nxt_st.tck_prev = pd_s[pin_mux_pkg::PD_TCK];
      nxt_st.tck_rise = pd_s[pin_mux_pkg::PD_TCK] & ~st_ff.tck_prev;
      if (pd_s[pin_mux_pkg::PD_TCK] & ~st_ff.tck_prev) begin
         // a pin taken over by the port leaves the test port seeing its pulled-up idle level
         nxt_st.tdi_smp = st_ff.pd_per[pin_mux_pkg::PD_TDI] ? pd_s[pin_mux_pkg::PD_TDI] : 1'b1; // RULE7
         nxt_st.tms_smp = st_ff.pd_per[pin_mux_pkg::PD_TMS] ? pd_s[pin_mux_pkg::PD_TMS] : 1'b1; // RULE9
      end
      if (~pd_s[pin_mux_pkg::PD_TCK] & st_ff.tck_prev) begin
         nxt_st.tdo_q = tap_tdo; // RULE8
      end
      nxt_st.wdog_n = ~ewm_assert; // RULE6
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.pa_per <= pin_mux_pkg::PA_PER_RST; // RULE1
         st_ff.pd_per <= pin_mux_pkg::PD_PER_RST; // RULE1
         st_ff.tck_prev <= 1'b1;
         st_ff.tdi_smp <= 1'b1;
         st_ff.tms_smp <= 1'b1;
         st_ff.wdog_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign tap_tdi = st_ff.tdi_smp;
   assign tap_tms = st_ff.tms_smp;
   assign tap_tck_rise = st_ff.tck_rise;
   assign ext_watchdog_out_n = st_ff.wdog_n;

   // port A: only bit 0 has a digital alternative; enable without it means analog input
   generate
      for (genvar i = 0; i < PA_W; i++) begin : g_pa
         if (i == pin_mux_pkg::PA_CMPC_BIT) begin : g_cmp
            assign pa_alt[i] = st_ff.pa_per[i] & st_ff.peripheral_select_reg[i]; // RULE16
         end else begin : g_plain
            assign pa_alt[i] = 1'b0;
         end
         assign pa_out[i] = pa_alt[i] ? comparator_c_out : st_ff.pa_data[i]; // RULE16
         assign pa_oe[i] = resetn & (pa_alt[i] | (~st_ff.pa_per[i] & st_ff.pa_dir[i])); // RULE14
         assign pa_analog_en[i] = st_ff.pa_per[i] & ~pa_alt[i]; // RULE17
      end
   endgenerate

   assign adc_a_ref_high_en = pa_analog_en[pin_mux_pkg::PA_REFH_BIT]
      & st_ff.adc_ctrl[pin_mux_pkg::ADC_REFH_SEL]; // RULE15
   assign adc_a_channel2_en = pa_analog_en[pin_mux_pkg::PA_REFH_BIT]
      & ~st_ff.adc_ctrl[pin_mux_pkg::ADC_REFH_SEL]; // RULE15
   assign adc_a_ref_low_en = pa_analog_en[pin_mux_pkg::PA_REFL_BIT]
      & st_ff.adc_ctrl[pin_mux_pkg::ADC_REFL_SEL]; // RULE15
   assign adc_a_channel3_en = pa_analog_en[pin_mux_pkg::PA_REFL_BIT]
      & ~st_ff.adc_ctrl[pin_mux_pkg::ADC_REFL_SEL]; // RULE15

   // port D: enable set means test or reset function, clear means port bit
   always_comb begin
      pd_out = st_ff.pd_data;
      pd_oe = st_ff.pd_dir & ~st_ff.pd_per; // RULE17
      if (st_ff.pd_per[pin_mux_pkg::PD_TDO]) begin
         pd_out[pin_mux_pkg::PD_TDO] = st_ff.tdo_q;
         pd_oe[pin_mux_pkg::PD_TDO] = tap_shift; // RULE8
      end
      // open drain: only ever pulls low
      pd_out[pin_mux_pkg::PD_RST] = 1'b0;
      pd_oe[pin_mux_pkg::PD_RST] = ~st_ff.pd_per[pin_mux_pkg::PD_RST]
         & st_ff.pd_dir[pin_mux_pkg::PD_RST] & ~st_ff.pd_data[pin_mux_pkg::PD_RST]; // RULE12
      if (!resetn) begin
         pd_oe = '0; // RULE13
      end
   end
   assign pd_pullup_en = {PD_W{~resetn}} | st_ff.pd_per | ~st_ff.pd_dir; // RULE13

   // pwm pins: outputs set in the fault mask lose drive on any fault input
   assign pwm_sub_pin_out = pwm_wave;
   assign pwm_sub_pin_oe = {PWM_W{resetn}} & ~st_ff.pwm_cap_mode
      & ~(st_ff.pwm_fmask & {PWM_W{fault_any}}); // RULE5
   assign pwm_capture = pwm_s & st_ff.pwm_cap_mode; // RULE4
   assign pwm_fault = fault_s; // RULE5

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   chk_reset_primary_fn: assert property (disable iff (1'b0) // RULE1
      !resetn |=> (st_ff.pa_per == pin_mux_pkg::PA_PER_RST)
      && (st_ff.pd_per == pin_mux_pkg::PD_PER_RST)) else $error("pin not primary after reset");
   chk_alt_needs_enable: assert property ( // RULE2
      pa_oe[0] && (pa_out[0] != st_ff.pa_data[0]) |-> st_ff.pa_per[0]
      && st_ff.peripheral_select_reg[0]) else $error("alternative routed without enable");
   chk_dir_write_bits: assert property ( // RULE3
      reg_wr && reg_addr == pin_mux_pkg::ADDR_PA_DIR |=> st_ff.pa_dir == $past(reg_wdata[PA_W-1:0]))
      else $error("direction write not taken");
   chk_pwm_mode_excl: assert property ( // RULE4
      (pwm_sub_pin_oe & st_ff.pwm_cap_mode) == '0) else $error("capture pin driven");
   chk_fault_disable: assert property ( // RULE5
      fault_any |-> (pwm_sub_pin_oe & st_ff.pwm_fmask) == '0) else $error("fault left output on");
   chk_wdog_low_active: assert property ( // RULE6
      ewm_assert |=> !ext_watchdog_out_n) else $error("watchdog pin not low");
   chk_tdi_sample_rise: assert property ( // RULE7
      pd_s[2] && !st_ff.tck_prev && st_ff.pd_per[0] |=> tap_tdi == $past(pd_s[0]) && tap_tck_rise)
      else $error("test data not sampled on rise");
   chk_tdo_tristate: assert property ( // RULE8
      st_ff.pd_per[1] && !tap_shift |-> !pd_oe[1]) else $error("test out driven outside shift");
   chk_tms_sample_rise: assert property ( // RULE9
      pd_s[2] && !st_ff.tck_prev && st_ff.pd_per[3] |=> tap_tms == $past(pd_s[3]))
      else $error("test mode not sampled on rise");
   chk_pin_reset_hold: assert property ( // RULE10
      pin_rst_req ##1 pin_rst_req |-> !sys_reset_n) else $error("reset pin did not hold reset");
   chk_gpio_reset_off: assert property ( // RULE12
      !st_ff.pd_per[4] |-> !pin_rst_req && !pd_out[4]
      && (pd_oe[4] == (st_ff.pd_dir[4] && !st_ff.pd_data[4]))) else $error("reset pin gpio bad");
   chk_reset_inputs: assert property (disable iff (1'b0) // RULE13
      !resetn |-> pa_oe == '0 && pd_oe == '0 && pd_pullup_en == '1)
      else $error("pins not pulled-up inputs in reset");
   chk_ref_exclusive: assert property ( // RULE15
      !(adc_a_channel2_en && adc_a_ref_high_en) && !(adc_a_channel3_en && adc_a_ref_low_en))
      else $error("channel and reference both on");
   chk_cmp_output: assert property ( // RULE16
      st_ff.pa_per[0] && st_ff.peripheral_select_reg[0] |-> pa_oe[0]
      && pa_out[0] == comparator_c_out) else $error("comparator not on pin");
   chk_gpio_owns_pin: assert property ( // RULE17
      (pa_oe & ~st_ff.pa_per) == (st_ff.pa_dir & ~st_ff.pa_per)) else $error("gpio lost pin");

   cov_cmp_routed: cover property (st_ff.pa_per[0] && st_ff.peripheral_select_reg[0]);
   cov_fault_hit: cover property (fault_any && (st_ff.pwm_fmask != '0));
   cov_tdo_driven: cover property (pd_oe[1] && st_ff.pd_per[1]);
   cov_pin_reset: cover property (pin_rst_req ##[1:40] $rose(sys_reset_n));
endmodule : pin_function_select

//--- sim/board_model.sv
`timescale 1ns/1ps
module board_model (
   input wire logic clk_sys,
   input wire logic [pin_mux_pkg::PA_W-1:0] pa_out,
   input wire logic [pin_mux_pkg::PA_W-1:0] pa_oe,
   input wire logic [pin_mux_pkg::PA_W-1:0] pa_drv,
   output logic [pin_mux_pkg::PA_W-1:0] pa_in,
   input wire logic [pin_mux_pkg::PD_W-1:0] pd_out,
   input wire logic [pin_mux_pkg::PD_W-1:0] pd_oe,
   input wire logic [pin_mux_pkg::PD_W-1:0] pd_pullup_en,
   input wire logic [pin_mux_pkg::PD_W-1:0] pd_drv,
   input wire logic [pin_mux_pkg::PD_W-1:0] pd_drv_en,
   output logic [pin_mux_pkg::PD_W-1:0] pd_in,
   input wire logic [pin_mux_pkg::PWM_W-1:0] pwm_sub_pin_out,
   input wire logic [pin_mux_pkg::PWM_W-1:0] pwm_sub_pin_oe,
   input wire logic [pin_mux_pkg::PWM_W-1:0] pwm_drv,
   output logic [pin_mux_pkg::PWM_W-1:0] pwm_sub_pin_in
);
   // a floating pad wanders each cycle so a stale level never passes for a match
   logic flip = 1'b0;
   always @(posedge clk_sys) flip <= ~flip;
   always_comb begin
      pa_in = (pa_oe & pa_out) | (~pa_oe & pa_drv);
      pwm_sub_pin_in = (pwm_sub_pin_oe & pwm_sub_pin_out) | (~pwm_sub_pin_oe & pwm_drv);
      for (int i = 0; i < pin_mux_pkg::PD_W; i++) begin
         // the reset pin is open drain: enabled means pulled low
         if (pd_oe[i])
            pd_in[i] = (i == pin_mux_pkg::PD_RST) ? 1'b0 : pd_out[i];
         else if (pd_drv_en[i])
            pd_in[i] = pd_drv[i];
         else
            pd_in[i] = pd_pullup_en[i] | flip;
      end
   end
endmodule : board_model

//--- sim/pin_function_select_tb.sv
`timescale 1ns/1ps
module pin_function_select_tb;
   localparam int RC = 4;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [pin_mux_pkg::ADDR_W-1:0] reg_addr = '0;
   logic [pin_mux_pkg::DATA_W-1:0] reg_wdata = '0;
   logic [pin_mux_pkg::DATA_W-1:0] reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, comparator_c_out = 1'b0, tap_tdo = 1'b0;
   logic tap_shift = 1'b0, watchdog_reset_source = 1'b0, sw_reset_req = 1'b0, ewm_assert = 1'b0;
   logic adc_a_channel2_en, adc_a_ref_high_en, adc_a_channel3_en, adc_a_ref_low_en;
   logic tap_tdi, tap_tms, tap_tck_rise, sys_reset_n, ext_watchdog_out_n;
   logic [pin_mux_pkg::PA_W-1:0] pa_in, pa_out, pa_oe, pa_analog_en;
   logic [pin_mux_pkg::PA_W-1:0] pa_drv = 12'h3C0;
   logic [pin_mux_pkg::PD_W-1:0] pd_in, pd_out, pd_oe, pd_pullup_en;
   logic [pin_mux_pkg::PD_W-1:0] pd_drv = 5'h10;
   logic [pin_mux_pkg::PD_W-1:0] pd_drv_en = 5'h1D;
   logic [pin_mux_pkg::PWM_W-1:0] pwm_sub_pin_in, pwm_sub_pin_out, pwm_sub_pin_oe, pwm_capture;
   logic [pin_mux_pkg::PWM_W-1:0] pwm_wave = 24'hA5A5A5;
   logic [pin_mux_pkg::PWM_W-1:0] pwm_drv = 24'h0F0F0F;
   logic [pin_mux_pkg::FAULT_W-1:0] pwm_fault_in = 4'h0;
   logic [pin_mux_pkg::FAULT_W-1:0] pwm_fault;
   int n_errors = 0;
   int checks = 0;

   pin_function_select #(.RST_CYCLES(RC)) pin_function_select_inst (.*);
   board_model board_model_inst (.*);

   always #2.5 clk_sys = ~clk_sys;

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [pin_mux_pkg::ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [pin_mux_pkg::ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      cmp(reg_rdata, exp);
   endtask : rd

   task automatic wait_up(output int n);
      n = 0;
      while (sys_reset_n !== 1'b1) begin
         tick(1);
         n++;
         if (n > 100) begin
            n_errors++;
            conclude();
         end
      end
   endtask : wait_up

   task automatic t_reset;
      int n;
      tick(4);
      cmp(32'({pa_oe, pd_oe}), 32'h0);
      cmp(32'(pd_pullup_en), 32'h1F);
      cmp(32'(pwm_sub_pin_oe), 32'h0);
      cmp(32'(sys_reset_n), 32'h0);
      @(posedge clk_sys);
      resetn <= 1'b1;
      tick(1);
      wait_up(n);
      rd(pin_mux_pkg::ADDR_PA_PER, 32'h0);
      rd(pin_mux_pkg::ADDR_PD_PER, 32'h1F);
      rd(4'hD, 32'h0);
      cmp(32'(ext_watchdog_out_n), 32'h1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_gpio;
      wr(pin_mux_pkg::ADDR_PA_DIR, 32'h00F);
      wr(pin_mux_pkg::ADDR_PA_DATA, 32'h0A4);
      cmp(32'({pa_oe, pa_out & pa_oe}), 32'h00F004);
      wr(pin_mux_pkg::ADDR_PA_DIR, 32'h00D);
      cmp(32'({pa_oe, pa_out & pa_oe}), 32'h00D004);
      rd(pin_mux_pkg::ADDR_PA_DIR, 32'h00D);
      rd(pin_mux_pkg::ADDR_PA_DATA, 32'h0A4);
      tick(3);
      rd(pin_mux_pkg::ADDR_PA_PIN, 32'h3C4);
      $display("test gpio done");
   endtask : t_gpio

   task automatic t_alt;
      wr(pin_mux_pkg::ADDR_PSEL, 32'h1);
      rd(pin_mux_pkg::ADDR_PSEL, 32'h1);
      @(posedge clk_sys);
      comparator_c_out <= 1'b1;
      tick(1);
      cmp(32'({pa_oe[0], pa_out[0]}), 32'h2);
      wr(pin_mux_pkg::ADDR_PA_PER, 32'h1);
      cmp(32'({pa_oe[0], pa_out[0]}), 32'h3);
      @(posedge clk_sys);
      comparator_c_out <= 1'b0;
      tick(1);
      cmp(32'({pa_oe[0], pa_out[0]}), 32'h2);
      wr(pin_mux_pkg::ADDR_PSEL, 32'h0);
      cmp(32'({pa_oe[0], pa_analog_en[0]}), 32'h1);
      $display("test alternate done");
   endtask : t_alt

   task automatic t_adc;
      wr(pin_mux_pkg::ADDR_PA_PER, 32'h00C);
      wr(pin_mux_pkg::ADDR_ADC_CTRL, 32'h0);
      cmp(32'({adc_a_channel2_en, adc_a_ref_high_en, adc_a_channel3_en, adc_a_ref_low_en,
               pa_analog_en[3:2]}), 32'h2B);
      wr(pin_mux_pkg::ADDR_ADC_CTRL, 32'h3);
      cmp(32'({adc_a_channel2_en, adc_a_ref_high_en, adc_a_channel3_en, adc_a_ref_low_en,
               pa_analog_en[3:2]}), 32'h17);
      rd(pin_mux_pkg::ADDR_ADC_CTRL, 32'h3);
      $display("test converter done");
   endtask : t_adc

   task automatic t_pwm;
      wr(pin_mux_pkg::ADDR_PWM_MODE, 32'h0);
      cmp(32'(pwm_sub_pin_oe), 32'hFFFFFF);
      cmp(32'(pwm_sub_pin_out), 32'hA5A5A5);
      wr(pin_mux_pkg::ADDR_PWM_MODE, 32'h000FFF);
      tick(3);
      cmp(32'(pwm_sub_pin_oe), 32'hFFF000);
      cmp(32'(pwm_capture), 32'h000F0F);
      rd(pin_mux_pkg::ADDR_PWM_MODE, 32'h000FFF);
      wr(pin_mux_pkg::ADDR_PWM_MODE, 32'h0);
      wr(pin_mux_pkg::ADDR_PWM_FMASK, 32'h0000FF);
      rd(pin_mux_pkg::ADDR_PWM_FMASK, 32'h0000FF);
      @(posedge clk_sys);
      pwm_fault_in <= 4'h1;
      tick(3);
      cmp(32'({pwm_fault, pwm_sub_pin_oe}), 32'h1FFFF00);
      rd(pin_mux_pkg::ADDR_STATUS, 32'h11);
      @(posedge clk_sys);
      pwm_fault_in <= 4'h0;
      tick(3);
      cmp(32'(pwm_sub_pin_oe), 32'hFFFFFF);
      $display("test pulse width done");
   endtask : t_pwm

   task automatic t_ewm;
      @(posedge clk_sys);
      ewm_assert <= 1'b1;
      tick(2);
      cmp(32'(ext_watchdog_out_n), 32'h0);
      @(posedge clk_sys);
      ewm_assert <= 1'b0;
      tick(2);
      cmp(32'(ext_watchdog_out_n), 32'h1);
      $display("test watchdog pin done");
   endtask : t_ewm

   task automatic tck_up;
      int k;
      @(posedge clk_sys);
      pd_drv[pin_mux_pkg::PD_TCK] <= 1'b1;
      for (k = 0; k < 8 && tap_tck_rise !== 1'b1; k++)
         tick(1);
      cmp(32'(k < 8), 32'h1);
   endtask : tck_up

   task automatic t_tap;
      @(posedge clk_sys);
      pd_drv <= 5'h19;
      tick(3);
      tck_up();
      cmp(32'({tap_tdi, tap_tms}), 32'h3);
      @(posedge clk_sys);
      pd_drv <= 5'h14;
      tap_shift <= 1'b1;
      tap_tdo <= 1'b1;
      tick(4);
      cmp(32'({tap_tdi, tap_tms, pd_oe[1]}), 32'h7);
      @(posedge clk_sys);
      pd_drv[pin_mux_pkg::PD_TCK] <= 1'b0;
      tick(4);
      cmp(32'(pd_out[1]), 32'h1);
      @(posedge clk_sys);
      tap_tdo <= 1'b0;
      tck_up();
      tick(3);
      cmp(32'({tap_tdi, tap_tms, pd_out[1]}), 32'h1);
      @(posedge clk_sys);
      tap_shift <= 1'b0;
      tick(1);
      cmp(32'(pd_oe[1]), 32'h0);
      $display("test test port done");
   endtask : t_tap

   task automatic t_pin_rst;
      int n;
      @(posedge clk_sys);
      pd_drv[pin_mux_pkg::PD_RST] <= 1'b0;
      tick(4);
      cmp(32'(sys_reset_n), 32'h0);
      @(posedge clk_sys);
      pd_drv[pin_mux_pkg::PD_RST] <= 1'b1;
      tick(1);
      wait_up(n);
      cmp(32'(n >= RC && n <= RC + 4), 32'h1);
      $display("test reset pin done");
   endtask : t_pin_rst

   task automatic t_port_rst;
      int n;
      wr(pin_mux_pkg::ADDR_PD_PER, 32'h0F);
      wr(pin_mux_pkg::ADDR_PD_DIR, 32'h10);
      wr(pin_mux_pkg::ADDR_PD_DATA, 32'h00);
      cmp(32'({pd_oe[4], pd_out[4]}), 32'h2);
      tick(8);
      cmp(32'(sys_reset_n), 32'h1);
      wr(pin_mux_pkg::ADDR_PD_DATA, 32'h10);
      cmp(32'(pd_oe[4]), 32'h0);
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys);
         watchdog_reset_source <= (s == 0);
         sw_reset_req <= (s == 1);
         @(posedge clk_sys);
         watchdog_reset_source <= 1'b0;
         sw_reset_req <= 1'b0;
         tick(1);
         cmp(32'(sys_reset_n), 32'h0);
         wait_up(n);
         cmp(32'(n <= RC + 4), 32'h1);
      end
      rd(pin_mux_pkg::ADDR_PD_DIR, 32'h10);
      rd(pin_mux_pkg::ADDR_PD_PIN, 32'h16);
      $display("test reset pin as port done");
   endtask : t_port_rst

   initial begin
      t_reset();
      t_gpio();
      t_alt();
      t_adc();
      t_pwm();
      t_ewm();
      t_tap();
      t_pin_rst();
      t_port_rst();
      conclude();
   end
endmodule : pin_function_select_tb
